// >>> common/ar_shot_regs.vh
// Register map, field layout, reset values and timing counts of the shot sequencer
// Assumes a 10 MHz clock and an APB master with 32-bit data
// Operation
// - Four shot settings sets, each programmable; current shot's set applies.
// - Shots above the configured maximum count are never used.
// - Wait the shot dead time, 0 to 300 s in 10 ms steps, before closing.
// - Block instantaneous elements whose per-shot inhibit flag is set.
// - Raise time overcurrent pickups by per-shot percentage, 0 to 100.
// - Select per-shot setpoint group; active choice leaves group unchanged.
// - Instantaneous operation trips breaker and starts a reclose sequence.
// - Breaker open resets phase instantaneous and time elements.
// - Close command and shot counter increment happen together.
// - No further trip: reset timer clears counter and returns to idle.
// - Time overcurrent timeout trips breaker and restarts the sequence.
// - New initiation below maximum runs another cycle with next shot.
// - New initiation at maximum enters lockout.
// - Shot limit is lower of maximum and supervision; lockout request wins.
`ifndef AR_SHOT_REGS_VH
`define AR_SHOT_REGS_VH

// Byte offsets
`define AR_CTRL_ADDR      12'h000
`define AR_STAT_ADDR      12'h004
`define AR_RESET_ADDR     12'h008
`define AR_SHOT_BASE      12'h010
`define AR_SHOT_STRIDE    12'h010
// Within a shot block: +0 dead time, +4 inhibit/group, +8 raise A, +C raise B
`define AR_SHOT_DEAD_OFS  2'h0
`define AR_SHOT_INH_OFS   2'h1
`define AR_SHOT_RAISEA    2'h2
`define AR_SHOT_RAISEB    2'h3

// Field layout
`define AR_CTRL_MAX_LSB   0
`define AR_CTRL_EN_BIT    4
`define AR_DEAD_W         15
`define AR_DEAD_MAX       15'h7530
`define AR_PCT_MAX        7'h64
`define AR_GRP_ACTIVE     3'h4
`define AR_GRP_LSB        8

// Reset values
`define AR_CTRL_RST       32'h0000_0011
`define AR_DEAD_RST       15'h0032
`define AR_RESET_RST      16'h03E8

// Timing: tick of 10 ms at 10 MHz
`define AR_TICK_MS        10
`define AR_CLK_KHZ        10000
`define AR_TICK_CYC       (`AR_TICK_MS * `AR_CLK_KHZ)

`endif

// >>> design/ar_shot_sequencer.v
// Autoreclose shot sequencer with APB settings registers
// Assumes element and breaker inputs come from pins and are synchronised here
`timescale 1ns/100ps
`include "ar_shot_regs.vh"
module ar_shot_sequencer #(
  parameter TICK_CYC = `AR_TICK_CYC
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        nrst_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // Protection element events
  input  wire        inst_operate_in,
  input  wire        toc_timeout_in,
  input  wire        brk_open_in,
  // Supervision limits
  input  wire [2:0]  sup_limit_in,
  input  wire        lockout_req_in,
  // Breaker and element outputs
  output reg         trip_out,
  output reg         close_out,
  output reg         elem_reset_out,
  output reg  [4:0]  inst_element_inhibit_out,
  output reg  [34:0] pickup_raise_percent_out,
  output reg  [2:0]  group_sel_out,
  output reg         group_sel_valid_out,
  output reg         lockout_out,
  output reg  [2:0]  shot_count_out
);
  // States
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_OPEN = 5'h02;
  localparam [4:0] ST_DEAD = 5'h04;
  localparam [4:0] ST_RCLM = 5'h08;
  localparam [4:0] ST_LOCK = 5'h10;

  // Registers
  reg  [31:0] ctrl_ff;
  reg  [15:0] reset_time_ff;
  reg  [14:0] dead_ff   [0:3];
  reg  [4:0]  inh_ff    [0:3];
  reg  [2:0]  grp_ff    [0:3];
  reg  [6:0]  raise_ff  [0:3][0:4];
  reg  [31:0] prdata_ff;
  reg  [4:0]  state_ff;
  reg  [4:0]  nxt_state;
  reg  [2:0]  shot_ff;
  reg  [2:0]  nxt_shot;
  reg  [2:0]  limit_ff;
  reg  [15:0] tcnt_ff;
  reg  [15:0] nxt_tcnt;
  reg         nxt_trip;
  reg         nxt_close;
  reg  [2:0]  sync1_ff;
  reg  [2:0]  sync2_ff;
  reg  [2:0]  prev_ff;
  wire        tick;
  wire        wr;
  wire        rd;
  wire [1:0]  sidx;
  wire [1:0]  fld;
  wire        shot_hit;
  wire        inst_rise;
  wire        toc_rise;
  wire        brk_open;
  wire        initiate;
  wire [2:0]  eff_limit;
  wire [1:0]  cur;
  wire        in_shot;
  integer     i;
  integer     j;

  function [6:0] clip_pct;
    input [6:0] v;
    begin
      clip_pct = (v > `AR_PCT_MAX) ? `AR_PCT_MAX : v;
    end
  endfunction

  function [2:0] min3;
    input [2:0] a;
    input [2:0] b;
    begin
      min3 = (a < b) ? a : b;
    end
  endfunction

  ar_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .tick_out (tick)
  );

  // APB decode, zero wait states
  assign wr          = psel_in & penable_in & pwrite_in;
  assign rd          = psel_in & ~pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = 1'b0;
  assign prdata_out  = prdata_ff;
  assign shot_hit    = (paddr_in >= `AR_SHOT_BASE) && (paddr_in < 12'h050)
                       && (paddr_in[1:0] == 2'h0);
  assign sidx        = paddr_in[5:4] - 2'h1;
  assign fld         = paddr_in[3:2];

  // Pin synchronisers
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= {brk_open_in, toc_timeout_in, inst_operate_in};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end
  assign inst_rise = sync2_ff[0] & ~prev_ff[0];
  assign toc_rise  = sync2_ff[1] & ~prev_ff[1];
  assign brk_open  = sync2_ff[2];
  assign initiate  = inst_rise | toc_rise;

  assign eff_limit = min3(ctrl_ff[2:0], (sup_limit_in == 3'h0) ? 3'h4 : sup_limit_in);
  assign cur       = (shot_ff == 3'h0) ? 2'h0 : shot_ff[1:0] - 2'h1;
  assign in_shot   = (shot_ff != 3'h0);

  // Register writes
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_ff       <= `AR_CTRL_RST;
      reset_time_ff <= `AR_RESET_RST;
      for (i = 0; i < 4; i = i + 1) begin
        dead_ff[i] <= `AR_DEAD_RST;
        inh_ff[i]  <= 5'h00;
        grp_ff[i]  <= `AR_GRP_ACTIVE;
        for (j = 0; j < 5; j = j + 1) begin
          raise_ff[i][j] <= 7'h00;
        end
      end
    end else if (wr) begin
      if (paddr_in == `AR_CTRL_ADDR) begin
        ctrl_ff <= {27'h0000000, pwdata_in[`AR_CTRL_EN_BIT],
                    1'b0, (pwdata_in[2:0] > 3'h4) ? 3'h4 : pwdata_in[2:0]};
      end else if (paddr_in == `AR_RESET_ADDR) begin
        reset_time_ff <= pwdata_in[15:0];
      end else if (shot_hit) begin
        case (fld)
          `AR_SHOT_DEAD_OFS: begin
            dead_ff[sidx] <= (pwdata_in[14:0] > `AR_DEAD_MAX) ? `AR_DEAD_MAX
                             : pwdata_in[14:0];
          end
          `AR_SHOT_INH_OFS: begin
            inh_ff[sidx] <= pwdata_in[4:0];
            grp_ff[sidx] <= (pwdata_in[10:8] > `AR_GRP_ACTIVE) ? `AR_GRP_ACTIVE
                            : pwdata_in[10:8];
          end
          `AR_SHOT_RAISEA: begin
            raise_ff[sidx][0] <= clip_pct(pwdata_in[6:0]);
            raise_ff[sidx][1] <= clip_pct(pwdata_in[14:8]);
            raise_ff[sidx][2] <= clip_pct(pwdata_in[22:16]);
            raise_ff[sidx][3] <= clip_pct(pwdata_in[30:24]);
          end
          default: begin
            raise_ff[sidx][4] <= clip_pct(pwdata_in[6:0]);
          end
        endcase
      end
    end
  end

  // Register reads
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd && !penable_in) begin
      if (paddr_in == `AR_CTRL_ADDR) begin
        prdata_ff <= ctrl_ff;
      end else if (paddr_in == `AR_STAT_ADDR) begin
        prdata_ff <= {20'h00000, limit_ff, 1'b0, shot_ff, state_ff};
      end else if (paddr_in == `AR_RESET_ADDR) begin
        prdata_ff <= {16'h0000, reset_time_ff};
      end else if (shot_hit) begin
        case (fld)
          `AR_SHOT_DEAD_OFS: prdata_ff <= {17'h00000, dead_ff[sidx]};
          `AR_SHOT_INH_OFS:  prdata_ff <= {21'h000000, grp_ff[sidx], 3'h0, inh_ff[sidx]};
          `AR_SHOT_RAISEA:   prdata_ff <= {1'b0, raise_ff[sidx][3], 1'b0, raise_ff[sidx][2],
                                           1'b0, raise_ff[sidx][1], 1'b0, raise_ff[sidx][0]};
          default:           prdata_ff <= {25'h0000000, raise_ff[sidx][4]};
        endcase
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Sequencer next state
  always @* begin
    nxt_state = state_ff;
    nxt_shot  = shot_ff;
    nxt_tcnt  = tick ? tcnt_ff + 16'h0001 : tcnt_ff;
    nxt_trip  = 1'b0;
    nxt_close = 1'b0;
    if (lockout_req_in && state_ff != ST_LOCK) begin
      nxt_state = ST_LOCK;
    end else begin
      case (state_ff)
        ST_IDLE, ST_RCLM: begin
          if (initiate) begin
            nxt_trip = 1'b1;
            nxt_tcnt = 16'h0000;
            if (!ctrl_ff[`AR_CTRL_EN_BIT] || shot_ff >= eff_limit) begin
              nxt_state = ST_LOCK;
            end else begin
              nxt_state = ST_OPEN;
            end
          end else if (state_ff == ST_RCLM && nxt_tcnt >= reset_time_ff) begin
            nxt_state = ST_IDLE;
            nxt_shot  = 3'h0;
          end
        end
        ST_OPEN: begin
          nxt_trip = 1'b1;
          nxt_tcnt = 16'h0000;
          if (brk_open) begin
            nxt_state = ST_DEAD;
          end
        end
        ST_DEAD: begin
          if (nxt_tcnt >= {1'b0, dead_ff[shot_ff[1:0]]}) begin
            nxt_close = 1'b1;
            nxt_shot  = shot_ff + 3'h1;
            nxt_state = ST_RCLM;
            nxt_tcnt  = 16'h0000;
          end
        end
        ST_LOCK: begin
          nxt_tcnt = 16'h0000;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers and outputs
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff                 <= ST_IDLE;
      shot_ff                  <= 3'h0;
      limit_ff                 <= 3'h4;
      tcnt_ff                  <= 16'h0000;
      trip_out                 <= 1'b0;
      close_out                <= 1'b0;
      elem_reset_out           <= 1'b0;
      inst_element_inhibit_out <= 5'h00;
      pickup_raise_percent_out <= 35'h0;
      group_sel_out            <= `AR_GRP_ACTIVE;
      group_sel_valid_out      <= 1'b0;
      lockout_out              <= 1'b0;
      shot_count_out           <= 3'h0;
    end else begin
      state_ff       <= nxt_state;
      shot_ff        <= nxt_shot;
      limit_ff       <= eff_limit;
      tcnt_ff        <= nxt_tcnt;
      trip_out       <= nxt_trip;
      close_out      <= nxt_close;
      shot_count_out <= nxt_shot;
      lockout_out    <= (nxt_state == ST_LOCK);
      elem_reset_out <= brk_open;
      if (in_shot) begin
        inst_element_inhibit_out <= inh_ff[cur];
        pickup_raise_percent_out <= {raise_ff[cur][4], raise_ff[cur][3], raise_ff[cur][2],
                                     raise_ff[cur][1], raise_ff[cur][0]};
        group_sel_out            <= grp_ff[cur];
        group_sel_valid_out      <= (grp_ff[cur] != `AR_GRP_ACTIVE);
      end else begin
        inst_element_inhibit_out <= 5'h00;
        pickup_raise_percent_out <= 35'h0;
        group_sel_out            <= `AR_GRP_ACTIVE;
        group_sel_valid_out      <= 1'b0;
      end
    end
  end
endmodule // ar_shot_sequencer

// >>> design/ar_tick_gen.v
// Periodic one-cycle tick every 10 ms
// Assumes clock_in at 10 MHz
`timescale 1ns/100ps
`include "ar_shot_regs.vh"
module ar_tick_gen #(
  parameter TICK_CYC = `AR_TICK_CYC
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        nrst_in,
  // Tick
  output wire        tick_out
);
  reg  [16:0] cnt_ff;
  wire        wrap;

  assign wrap     = (cnt_ff == TICK_CYC[16:0] - 17'h00001);
  assign tick_out = wrap;

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= 17'h00000;
    end else if (wrap) begin
      cnt_ff <= 17'h00000;
    end else begin
      cnt_ff <= cnt_ff + 17'h00001;
    end
  end
endmodule // ar_tick_gen

// >>> verif/ar_breaker_model.sv
// Breaker model: opens after a trip, closes after a close pulse
// Assumes trip and close come on the same clock
`timescale 1ns/100ps
module ar_breaker_model (
  // Clock and reset
  input  wire  clock_in,
  input  wire  nrst_in,
  // Commands
  input  wire  trip_in,
  input  wire  close_in,
  // Status
  output logic open_out
);
  int dly_ff;
  // Mechanism takes four cycles either way
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      open_out <= 1'b0;
      dly_ff <= 0;
    end else if (dly_ff != 0) begin
      dly_ff <= dly_ff - 1;
      if (dly_ff == 1) open_out <= !open_out;
    end else if ((trip_in && !open_out) || (close_in && open_out)) begin
      dly_ff <= 4;
    end
  end
endmodule // ar_breaker_model

// >>> verif/ar_shot_sequencer_properties.sv
// Checker for the shot sequencer top ports
// Assumes one clock domain and the asynchronous active low reset
`timescale 1ns/100ps
module ar_shot_sequencer_properties (
  // Clock and reset
  input wire        clock_in,
  input wire        nrst_in,
  // Design inputs
  input wire        inst_operate_in,
  input wire        toc_timeout_in,
  input wire        brk_open_in,
  input wire        lockout_req_in,
  input wire [2:0]  sup_limit_in,
  // Design outputs
  input wire        trip_out,
  input wire        close_out,
  input wire        elem_reset_out,
  input wire        group_sel_valid_out,
  input wire        lockout_out,
  input wire [2:0]  group_sel_out,
  input wire [2:0]  shot_count_out,
  input wire [34:0] pickup_raise_percent_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence s_pulse;
    close_out ##1 !close_out;
  endsequence
  sequence s_trip;
    ##[1:5] trip_out;
  endsequence
  close_pulse_a: assert property (close_out |-> s_pulse)
    else $error("close longer than one cycle");
  close_count_a: assert property (close_out |-> ##[0:1] $changed(shot_count_out))
    else $error("close without shot advance");
  close_open_a: assert property (close_out |-> elem_reset_out)
    else $error("close while breaker not open");
  close_limit_a: assert property (close_out |->
    (sup_limit_in == 3'h0 || shot_count_out <= sup_limit_in))
    else $error("close beyond supervision limit");
  lock_noclose_a: assert property (lockout_out |-> !close_out)
    else $error("close during lockout");
  lock_hold_a: assert property (lockout_out |=> lockout_out)
    else $error("lockout left without reset");
  lock_req_a: assert property (lockout_req_in |-> ##[1:3] lockout_out)
    else $error("lockout request ignored");
  trip_init_a: assert property ($rose(inst_operate_in || toc_timeout_in)
    && !elem_reset_out && !lockout_out |-> s_trip)
    else $error("initiation without trip");
  elem_reset_a: assert property ($rose(brk_open_in) |-> ##[1:4] elem_reset_out)
    else $error("elements not reset on open");
  group_valid_a: assert property (group_sel_valid_out |-> group_sel_out != 3'h4)
    else $error("group switch with active choice");
  pct_range_a: assert property (pickup_raise_percent_out[6:0] <= 7'h64
    && pickup_raise_percent_out[13:7] <= 7'h64 && pickup_raise_percent_out[20:14] <= 7'h64
    && pickup_raise_percent_out[27:21] <= 7'h64 && pickup_raise_percent_out[34:28] <= 7'h64)
    else $error("pickup raise above limit");
endmodule // ar_shot_sequencer_properties

// >>> verif/ar_shot_sequencer_tb_top.sv
// Bench for the shot sequencer: APB setup, breaker model, sequence checks
// Assumes TICK_CYC shortened to 10 cycles
`timescale 1ns/100ps
module ar_shot_sequencer_tb_top;
  logic        clock_in = 0, nrst_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic        inst = 0, toc = 0, lreq = 0;
  logic [2:0]  sup = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  wire  [31:0] prdata;
  wire         pready, perr, trip, close, erst, gval, lock, brk;
  wire  [4:0]  inh;
  wire  [34:0] pct;
  wire  [2:0]  grp, shot;
  int          errors = 0, cmp_count = 0, n;
  always #50 clock_in = ~clock_in;
  ar_shot_sequencer #(.TICK_CYC(10)) dut (.clock_in, .nrst_in, .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .inst_operate_in(inst),
    .toc_timeout_in(toc), .brk_open_in(brk), .sup_limit_in(sup), .lockout_req_in(lreq),
    .trip_out(trip), .close_out(close), .elem_reset_out(erst),
    .inst_element_inhibit_out(inh), .pickup_raise_percent_out(pct), .group_sel_out(grp),
    .group_sel_valid_out(gval), .lockout_out(lock), .shot_count_out(shot));
  ar_breaker_model brk_m (.clock_in, .nrst_in, .trip_in(trip), .close_in(close),
    .open_out(brk));
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clock_in);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1;
    do @(posedge clock_in); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task rchk(logic [11:0] a, logic [31:0] e);
    apb(0, a, 0);
    chk("read data", e, q);
    chk("slave error", 0, perr);
  endtask
  task pulse(logic t);
    @(posedge clock_in);
    if (t) toc <= 1; else inst <= 1;
    repeat (3) @(posedge clock_in);
    toc <= 0;
    inst <= 0;
  endtask
  function logic sel(int w);
    return w == 0 ? close : w == 1 ? lock : trip;
  endfunction
  task wait_hi(int w, int lim);
    n = 0;
    forever begin
      @(posedge clock_in);
      #1;
      if (sel(w) === 1'b1 || n == lim) break;
      n++;
    end
  endtask
  task rst;
    @(posedge clock_in);
    nrst_in <= 0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1;
  endtask
  task t_regs;
    rchk(12'h000, 32'h0000_0011);
    rchk(12'h008, 32'h0000_03E8);
    apb(1, 12'h010, 32'h0000_FFFF);
    apb(1, 12'h018, 32'hFFFF_FFFF);
    rchk(12'h010, 32'h0000_7530);
    rchk(12'h018, 32'h6464_6464);
    rchk(12'h040, 32'h0000_0032);
    rchk(12'hFFC, 32'h0000_0000);
  endtask
  task t_cycle;
    apb(1, 12'h000, 32'h0000_0012);
    apb(1, 12'h010, 32'h0000_0003);
    apb(1, 12'h014, 32'h0000_0105);
    apb(1, 12'h018, 32'h0000_0014);
    apb(1, 12'h01C, 32'h0000_0064);
    apb(1, 12'h030, 32'h0000_0001);
    pulse(0);
    wait_hi(2, 10);
    chk("trip", 1, trip);
    wait_hi(0, 60);
    chk("dead time", 1, n >= 15 && n < 50);
    repeat (2) @(posedge clock_in);
    chk("shot", 1, shot);
    chk("inhibit", 5'h05, inh);
    chk("group", 3'h1, grp);
    chk("group valid", 1, gval);
    chk("pickup 0", 7'h14, pct[6:0]);
    chk("pickup 4", 7'h64, pct[34:28]);
    repeat (15) @(posedge clock_in);
    pulse(1);
    wait_hi(0, 700);
    repeat (2) @(posedge clock_in);
    chk("shot 2", 2, shot);
    repeat (15) @(posedge clock_in);
    pulse(1);
    wait_hi(1, 20);
    chk("lockout", 1, lock);
    wait_hi(0, 60);
    chk("no close", 60, n);
  endtask
  task t_reset;
    rst;
    apb(1, 12'h008, 32'h0000_0005);
    apb(1, 12'h010, 32'h0000_0002);
    pulse(0);
    wait_hi(0, 60);
    chk("close", 1, close);
    repeat (2) @(posedge clock_in);
    chk("group kept", 3'h4, grp);
    chk("no switch", 0, gval);
    repeat (120) @(posedge clock_in);
    apb(0, 12'h004, 0);
    chk("state", 8'h01, q[7:0]);
    chk("shot idle", 0, shot);
    apb(1, 12'h000, 32'h0000_0001);
    pulse(0);
    wait_hi(1, 20);
    chk("disabled lockout", 1, lock);
  endtask
  task t_sup;
    rst;
    apb(1, 12'h000, 32'h0000_0014);
    apb(1, 12'h010, 32'h0000_0002);
    sup <= 3'h1;
    pulse(0);
    wait_hi(0, 60);
    chk("close", 1, close);
    apb(0, 12'h004, 0);
    chk("limit", 3'h1, q[11:9]);
    repeat (15) @(posedge clock_in);
    pulse(1);
    wait_hi(1, 20);
    chk("lockout", 1, lock);
    rst;
    lreq <= 1;
    wait_hi(1, 10);
    chk("lockout req", 1, lock);
    @(posedge clock_in);
    lreq <= 0;
    sup <= 0;
  endtask
  task conclude;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst;
    t_regs;
    t_cycle;
    t_reset;
    t_sup;
    conclude;
  end
  // Watchdog
  initial begin
    #2_000_000;
    errors++;
    conclude;
  end
endmodule // ar_shot_sequencer_tb_top
bind ar_shot_sequencer ar_shot_sequencer_properties chk_u (.clock_in, .nrst_in,
  .inst_operate_in, .toc_timeout_in, .brk_open_in, .lockout_req_in, .sup_limit_in,
  .trip_out, .close_out, .elem_reset_out, .group_sel_out, .group_sel_valid_out,
  .lockout_out, .shot_count_out, .pickup_raise_percent_out);
